// ### logic/cpp_pkg.sv
package cpp_pkg;

    // mode field codes of the compare mode select
    localparam logic [2:0] CPP_MODE_OFF = 3'h0;
    localparam logic [2:0] CPP_MODE_CONT = 3'h5;
    localparam logic [2:0] CPP_MODE_PWM = 3'h6;
    localparam logic [2:0] CPP_MODE_PWM_FAULT = 3'h7;
    localparam int CPP_WIDTH = 32;
    localparam logic [31:0] CPP_ZERO = 32'h00000000;
    localparam logic [31:0] CPP_LOW_MASK = 32'h0000FFFF;
    // channel number served by fault input a up to this value
    localparam int CPP_FAULT_A_LAST = 3;
    localparam int CPP_DEFAULT_CHANNEL = 1;

    // channel configuration carried as one bundle
    typedef struct packed {
        logic enable;
        logic [2:0] mode;
        logic wide;
        logic time_base_select;
    } cpp_ctrl_t;

    // one time base as seen by the channel
    typedef struct packed {
        logic [31:0] count;
        logic [31:0] period;
    } cpp_base_t;

endpackage : cpp_pkg

// ### logic/cpp_channel.sv
`timescale 1ns/100ps
module cpp_channel
    import cpp_pkg::*;
#(
    parameter int CHANNEL = CPP_DEFAULT_CHANNEL
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire cpp_ctrl_t ctrl_in,
    input wire logic mode_write_in,
    input wire logic primary_write_in,
    input wire logic [31:0] primary_data_in,
    input wire logic [31:0] secondary_compare_value_in,
    input wire cpp_base_t base_x_in,
    input wire cpp_base_t base_y_in,
    input wire logic fault_input_a_in,
    input wire logic fault_input_b_in,
    input wire logic port_latch_in,
    input wire logic port_output_enable_in,
    output logic [31:0] primary_compare_value_out,
    output logic compare_irq_flag_out,
    output logic fault_status_out,
    output logic compare_output_pin_out,
    output logic compare_output_oe_out
);

    ////////////////////////////////////////////////////////////////////////
    // width masking, shared by every comparison
    function automatic logic [31:0] cpp_fit(input logic [31:0] v, input logic wide);
        cpp_fit = wide ? v : (v & CPP_LOW_MASK);
    endfunction : cpp_fit

    logic fault_a_meta_reg;
    logic fault_a_sync_reg;
    logic fault_b_meta_reg;
    logic fault_b_sync_reg;
    logic pin_reg;
    logic flag_reg;
    logic fault_reg;
    logic [31:0] duty_reg;
    logic [31:0] count;
    logic [31:0] period;
    logic [31:0] secondary;
    logic period_match;
    logic primary_match;
    logic secondary_match;
    logic is_pwm;
    logic is_cont;
    logic fault_seen;
    logic pwm_next;
    logic pwm_start;

    ////////////////////////////////////////////////////////////////////////
    // time base choice and compare events
    always_comb begin
        count = cpp_fit(ctrl_in.time_base_select ? base_y_in.count : base_x_in.count,
                        ctrl_in.wide);
        period = cpp_fit(ctrl_in.time_base_select ? base_y_in.period : base_x_in.period,
                         ctrl_in.wide);
        secondary = cpp_fit(secondary_compare_value_in, ctrl_in.wide);
    end

    assign period_match = (count == period);
    assign primary_match = (count == cpp_fit(duty_reg, ctrl_in.wide));
    assign secondary_match = (count == secondary);
    assign is_cont = ctrl_in.enable && (ctrl_in.mode == CPP_MODE_CONT);
    assign is_pwm = ctrl_in.enable &&
                    (ctrl_in.mode == CPP_MODE_PWM || ctrl_in.mode == CPP_MODE_PWM_FAULT);

    // fault input synchronisers, two stages each
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault_a_meta_reg <= 1'b0;
            fault_a_sync_reg <= 1'b0;
            fault_b_meta_reg <= 1'b0;
            fault_b_sync_reg <= 1'b0;
        end else begin
            fault_a_meta_reg <= fault_input_a_in;
            fault_a_sync_reg <= fault_a_meta_reg;
            fault_b_meta_reg <= fault_input_b_in;
            fault_b_sync_reg <= fault_b_meta_reg;
        end
    end

    // fault source by channel number
    assign fault_seen = (CHANNEL <= CPP_FAULT_A_LAST) ? fault_a_sync_reg
                                                      : fault_b_sync_reg;

    ////////////////////////////////////////////////////////////////////////
    // active duty register: software load outside PWM, buffered copy in PWM
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            duty_reg <= CPP_ZERO;
        end else if (is_pwm) begin
            if (period_match) begin
                duty_reg <= secondary_compare_value_in;
            end
        end else if (primary_write_in) begin
            duty_reg <= primary_data_in;
        end
    end

    // sticky fault status, cleared by a mode write unless the fault is still seen in fault mode
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault_reg <= 1'b0;
        end else if (ctrl_in.enable && ctrl_in.mode == CPP_MODE_PWM_FAULT && fault_seen) begin
            fault_reg <= 1'b1;
        end else if (mode_write_in) begin
            fault_reg <= 1'b0;
        end
    end

    // compare flag pulse on each secondary match in continuous mode, except in a mode write cycle
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= is_cont && !mode_write_in && secondary_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM level for the next count: high from period start until duty
    always_comb begin
        if (period_match) begin
            pwm_next = (cpp_fit(secondary_compare_value_in, ctrl_in.wide) != CPP_ZERO);
        end else if (cpp_fit(duty_reg, ctrl_in.wide) > period) begin
            pwm_next = 1'b1;
        end else if (count + 32'h00000001 == cpp_fit(duty_reg, ctrl_in.wide)) begin
            pwm_next = 1'b0;
        end else begin
            pwm_next = pin_reg;
        end
    end

    // opening level after a PWM mode write: the held duty shapes the first period
    always_comb begin
        if (period_match) begin
            pwm_start = pwm_next;
        end else begin
            pwm_start = (cpp_fit(duty_reg, ctrl_in.wide) > period) ||
                        (count + 32'h00000001 < cpp_fit(duty_reg, ctrl_in.wide));
        end
    end

    // output pin state
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_reg <= 1'b0;
        end else if (mode_write_in && is_pwm) begin
            pin_reg <= pwm_start &&
                       !(ctrl_in.mode == CPP_MODE_PWM_FAULT && fault_seen);
        end else if (mode_write_in || !ctrl_in.enable) begin
            pin_reg <= 1'b0;
        end else if (is_cont) begin
            if (secondary_match) begin
                pin_reg <= 1'b0;
            end else if (primary_match) begin
                pin_reg <= 1'b1;
            end
        end else if (is_pwm) begin
            if (fault_reg || (ctrl_in.mode == CPP_MODE_PWM_FAULT && fault_seen)) begin
                pin_reg <= 1'b0;
            end else begin
                pin_reg <= pwm_next;
            end
        end
    end

    // pin ownership follows enable
    assign compare_output_pin_out = ctrl_in.enable ? pin_reg : port_latch_in;
    assign compare_output_oe_out = ctrl_in.enable ? 1'b1 : port_output_enable_in;
    assign primary_compare_value_out = duty_reg;
    assign compare_irq_flag_out = flag_reg;
    assign fault_status_out = fault_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_cont_sec;
        is_cont && !mode_write_in && secondary_match;
    endsequence

    chk_flag_on_match: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        s_cont_sec |=> compare_irq_flag_out)
        else $error("flag missing after secondary match");

    chk_flag_cause: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        compare_irq_flag_out |-> $past(secondary_match))
        else $error("flag without match");

    chk_cont_fall: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        s_cont_sec |=> !pin_reg)
        else $error("pin not low after secondary match");

    chk_cont_rise: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        is_cont && !mode_write_in && primary_match && !secondary_match |=> pin_reg)
        else $error("pin not high after primary match");

    chk_mode_write_low: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        mode_write_in && !is_pwm |=> !pin_reg)
        else $error("pin not forced low on mode write");

    chk_pwm_start_high: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        mode_write_in && ctrl_in.enable && ctrl_in.mode == CPP_MODE_PWM && count == CPP_ZERO &&
        !period_match && cpp_fit(duty_reg, ctrl_in.wide) > 32'h00000001 |=> pin_reg)
        else $error("pin not high at first PWM period");

    chk_duty_load: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        is_pwm && period_match |=> duty_reg == $past(secondary_compare_value_in))
        else $error("duty not copied at period match");

    chk_duty_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        is_pwm && !period_match |=> $stable(duty_reg))
        else $error("duty changed mid period");

    chk_fault_low: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        fault_reg && is_pwm && !mode_write_in |=> !pin_reg)
        else $error("pin high during fault");

    chk_pin_owner: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        !ctrl_in.enable |-> compare_output_pin_out == port_latch_in)
        else $error("pin not returned to port latch");

endmodule : cpp_channel

// ### tb/cpp_timer_model.sv
`timescale 1ns/100ps
module cpp_timer_model
    import cpp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [31:0] period_x_in,
    input wire logic [31:0] period_y_in,
    output cpp_base_t base_x_out,
    output cpp_base_t base_y_out
);
    logic [31:0] cnt_x_reg;
    logic [31:0] cnt_y_reg;
    ////////////////////////////////////////////////////////////////////////
    // two time bases, each clearing to zero at its period and counting on
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_x_reg <= CPP_ZERO;
            cnt_y_reg <= CPP_ZERO;
        end else begin
            cnt_x_reg <= (cnt_x_reg == period_x_in) ? CPP_ZERO : cnt_x_reg + 32'h1;
            cnt_y_reg <= (cnt_y_reg == period_y_in) ? CPP_ZERO : cnt_y_reg + 32'h1;
        end
    end
    // period travels beside the count
    assign base_x_out = {cnt_x_reg, period_x_in};
    assign base_y_out = {cnt_y_reg, period_y_in};
endmodule : cpp_timer_model

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
    import cpp_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    cpp_ctrl_t ctrl = '0;
    logic mode_wr = 1'b0, prim_wr = 1'b0, fa = 1'b0, fb = 1'b0, latch = 1'b0, poe = 1'b0;
    logic [31:0] prim = 32'h0, sec = 32'h0, per_x = 32'h7, per_y = 32'h3, prim_out;
    logic flag, fstat, pin, oe;
    logic [31:0] duty [4] = '{32'h0, 32'h5, 32'h7, 32'h9};
    cpp_base_t bx, by;
    int num_errors = 0;
    int num_checks = 0;
    ////////////////////////////////////////////////////////////////////////
    // clock and instances
    always #5 mclk_in = ~mclk_in;
    cpp_timer_model i_tmr (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .period_x_in(per_x),
        .period_y_in(per_y), .base_x_out(bx), .base_y_out(by));
    cpp_channel i_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .ctrl_in(ctrl),
        .mode_write_in(mode_wr), .primary_write_in(prim_wr), .primary_data_in(prim),
        .secondary_compare_value_in(sec), .base_x_in(bx), .base_y_in(by),
        .fault_input_a_in(fa), .fault_input_b_in(fb), .port_latch_in(latch),
        .port_output_enable_in(poe), .primary_compare_value_out(prim_out),
        .compare_irq_flag_out(flag), .fault_status_out(fstat),
        .compare_output_pin_out(pin), .compare_output_oe_out(oe));
    ////////////////////////////////////////////////////////////////////////
    // report, compare and access tasks
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : tick
    task automatic set_mode(input logic [2:0] m);
        ctrl.mode = m;
        mode_wr = 1'b1;
        tick(1);
        mode_wr = 1'b0;
    endtask : set_mode
    task automatic wait_zero;
        int i;
        for (i = 0; i < 100; i++) begin
            tick(1);
            if ((ctrl.time_base_select ? by.count : bx.count) === CPP_ZERO) break;
        end
        if (i == 100) begin
            num_errors++;
            print_verdict();
        end
    endtask : wait_zero
    task automatic measure(input int n, input logic [31:0] hi_exp, input logic [31:0] fl_exp);
        logic [31:0] hi;
        logic [31:0] fl;
        hi = '0;
        fl = '0;
        repeat (n) begin
            tick(1);
            hi += {31'h0, pin};
            fl += {31'h0, flag};
        end
        check(hi, hi_exp);
        check(fl, fl_exp);
    endtask : measure
    task automatic run_cont(input logic w, t, input logic [31:0] p, s, input int n,
        input logic [31:0] hi, fl);
        ctrl.wide = w;
        ctrl.time_base_select = t;
        set_mode(CPP_MODE_CONT);
        prim = p;
        prim_wr = 1'b1;
        sec = s;
        tick(1);
        prim_wr = 1'b0;
        wait_zero();
        wait_zero();
        measure(n, hi, fl);
    endtask : run_cont
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        ctrl.enable = 1'b1;
        tick(2);
        reset_n_in = 1'b1;
        run_cont(1, 0, 32'h2, 32'h4, 16, 32'h4, 32'h2);
        run_cont(0, 0, 32'h10002, 32'h10004, 16, 32'h4, 32'h2);
        run_cont(1, 0, 32'h10002, 32'h10004, 16, 32'h0, 32'h0);
        run_cont(0, 1, 32'h1, 32'h3, 8, 32'h4, 32'h2);
        check({31'h0, oe}, 32'h1);
        $display("continuous pulse test done");
        ctrl.time_base_select = 1'b0;
        ctrl.wide = 1'b1;
        prim = 32'h3;
        prim_wr = 1'b1;
        sec = 32'h5;
        tick(1);
        prim_wr = 1'b0;
        wait_zero();
        set_mode(CPP_MODE_PWM);
        check(prim_out, 32'h3);
        check({31'h0, pin}, 32'h1);
        tick(2);
        check({31'h0, pin}, 32'h0);
        wait_zero();
        check(prim_out, 32'h5);
        prim = 32'h1;
        prim_wr = 1'b1;
        tick(1);
        prim_wr = 1'b0;
        check(prim_out, 32'h5);
        for (int m = 6; m < 8; m++) begin
            set_mode(m[2:0]);
            foreach (duty[i]) begin
                sec = duty[i];
                wait_zero();
                wait_zero();
                measure(16, (duty[i] > 7) ? 32'h10 : 32'h2 * duty[i], 32'h0);
            end
        end
        wait_zero();
        set_mode(CPP_MODE_CONT);
        check({31'h0, pin}, 32'h0);
        $display("pwm test done");
        sec = 32'h9;
        set_mode(CPP_MODE_PWM_FAULT); // irq enable is kept outside the channel
        wait_zero();
        wait_zero();
        fb = 1'b1;
        tick(5);
        check({30'h0, fstat, pin}, 32'h1);
        fa = 1'b1;
        tick(5);
        fa = 1'b0;
        tick(3);
        check({30'h0, fstat, pin}, 32'h2);
        set_mode(CPP_MODE_PWM_FAULT);
        tick(1);
        check({31'h0, fstat}, 32'h0);
        $display("fault test done");
        ctrl.enable = 1'b0;
        latch = 1'b1;
        tick(1);
        check({30'h0, pin, oe}, 32'h2);
        latch = 1'b0;
        poe = 1'b1;
        tick(1);
        check({30'h0, pin, oe}, 32'h1);
        $display("pin handback test done");
        print_verdict();
    end
endmodule : tb
